// file: rtdwe_consts.vh
// Constants of the two-channel temperature word encoder.
// Assumes a 40 MHz CLOCK; included by its bare name from every design file.
`ifndef RTDWE_CONSTS_VH
`define RTDWE_CONSTS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define RTDWE_CLK_HZ 40000000
`define RTDWE_CONV_TIME_MS 200
`define RTDWE_READY_TIME_S 3
// Cycle counts at 40 MHz, sized so no integer is cut on the way in
`define RTDWE_CONV_CYCLES 27'h07A1200
`define RTDWE_READY_CYCLES 27'h7270E00

// ****************************************************************
// Reported codes and thresholds, tenths of a degree
// ****************************************************************
`define RTDWE_CODE_DISCONNECT 16'h4E20
`define RTDWE_CODE_NOT_READY 16'h4E21
`define RTDWE_SAT_LOW 16'hF79A
`define RTDWE_SAT_HIGH 16'h21CA
`define RTDWE_DISC_LOW 16'hF704
`define RTDWE_DISC_HIGH 16'h2328

// ****************************************************************
// Input image word numbers per slot
// ****************************************************************
`define RTDWE_SLOT0_BASE 8'h0A
`define RTDWE_SLOT1_BASE 8'h14

// ****************************************************************
// Sample queue
// ****************************************************************
`define RTDWE_Q_WIDTH 18
`define RTDWE_Q_DEPTH 32
`define RTDWE_Q_AW 5
`define RTDWE_Q_CHAN_BIT 17
`define RTDWE_Q_OPEN_BIT 16

`endif

// file: rtdwe_fifo.v
// Sample queue between the front end and the encoder.
// Assumes both sides on one clock; read data come out of a register.
`timescale 1ns/1ps
`include "rtdwe_consts.vh"

module rtdwe_fifo #(
  parameter WIDTH = `RTDWE_Q_WIDTH,
  parameter DEPTH = `RTDWE_Q_DEPTH,
  parameter AW = `RTDWE_Q_AW
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data
);

  localparam [AW:0] FULL_CNT = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;

  wire push = in_valid && in_ready;
  wire fetch = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);

  assign in_ready = (count != FULL_CNT);

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (fetch) begin
        rd_ptr <= rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      case ({push, fetch})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end

endmodule // rtdwe_fifo

// file: rtdwe_top.v
// Two-channel resistance-temperature word encoder, top level.
// Assumes a front end on CLOCK delivering signed tenths per channel;
// the watchdog fault and slot strap come from pins and are synchronised.
`timescale 1ns/1ps
`include "rtdwe_consts.vh"

module rtdwe_top #(
  parameter [26:0] CONV_CYCLES = `RTDWE_CONV_CYCLES,
  parameter [26:0] READY_CYCLES = `RTDWE_READY_CYCLES
) (
  // Clock and reset
  input wire CLOCK,
  input wire RST,
  // Front end samples
  input wire SAMPLE_VALID,
  output wire SAMPLE_READY,
  input wire SAMPLE_CHANNEL,
  input wire SAMPLE_OPEN,
  input wire [15:0] SAMPLE_TENTHS,
  // Cassette processor status and slot strap
  input wire WATCHDOG_FAULT,
  input wire SLOT_SELECT,
  // Input image words
  output reg [15:0] FIRST_CHANNEL_WORD,
  output reg [15:0] SECOND_CHANNEL_WORD,
  output reg [7:0] FIRST_WORD_ADDR,
  output reg [7:0] SECOND_WORD_ADDR,
  output reg WORD_UPDATE
);

  // ****************************************************************
  // Encoding of one measured value
  // ****************************************************************
  function [15:0] rtdwe_encode;
    input open_wire;
    input [15:0] raw;
    reg signed [15:0] t;
    begin
      t = raw;
      if (open_wire) begin
        rtdwe_encode = `RTDWE_CODE_DISCONNECT;
      end else if (t < $signed(`RTDWE_DISC_LOW) || t > $signed(`RTDWE_DISC_HIGH)) begin
        rtdwe_encode = `RTDWE_CODE_DISCONNECT;
      end else if (t < $signed(`RTDWE_SAT_LOW)) begin
        rtdwe_encode = `RTDWE_SAT_LOW;
      end else if (t > $signed(`RTDWE_SAT_HIGH)) begin
        rtdwe_encode = `RTDWE_SAT_HIGH;
      end else begin
        // Normal span and reference band pass through unchanged
        rtdwe_encode = raw;
      end
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers and slot strap
  // ****************************************************************
  reg wdog_meta;
  reg wdog_sync;
  reg slot_meta;
  reg slot_sync;
  reg [1:0] settle;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wdog_meta <= 1'b0;
      wdog_sync <= 1'b0;
      slot_meta <= 1'b0;
      slot_sync <= 1'b0;
    end else begin
      wdog_meta <= WATCHDOG_FAULT;
      wdog_sync <= wdog_meta;
      slot_meta <= SLOT_SELECT;
      slot_sync <= slot_meta;
    end
  end

  // Strap caught once, after the synchroniser has filled
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      settle <= 2'h0;
      FIRST_WORD_ADDR <= `RTDWE_SLOT0_BASE;
      SECOND_WORD_ADDR <= `RTDWE_SLOT0_BASE + 8'h01;
    end else begin
      if (settle != 2'h3) begin
        settle <= settle + 2'h1;
      end
      if (settle == 2'h2) begin
        FIRST_WORD_ADDR <= slot_sync ? `RTDWE_SLOT1_BASE : `RTDWE_SLOT0_BASE;
        SECOND_WORD_ADDR <= (slot_sync ? `RTDWE_SLOT1_BASE : `RTDWE_SLOT0_BASE)
                            + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Conversion cycle and power-up readiness
  // ****************************************************************
  reg [26:0] conv_cnt;
  reg tick;
  reg [26:0] pu_cnt;
  wire pu_busy = (pu_cnt != READY_CYCLES);

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      conv_cnt <= 27'h0000000;
      tick <= 1'b0;
      pu_cnt <= 27'h0000000;
    end else begin
      if (conv_cnt == CONV_CYCLES - 27'h0000001) begin
        conv_cnt <= 27'h0000000;
        tick <= 1'b1;
      end else begin
        conv_cnt <= conv_cnt + 27'h0000001;
        tick <= 1'b0;
      end
      if (pu_busy) begin
        pu_cnt <= pu_cnt + 27'h0000001;
      end
    end
  end

  // ****************************************************************
  // Sample queue
  // ****************************************************************
  wire q_valid;
  wire [17:0] q_data;
  // Draining halts while the cassette processor is faulted and on the
  // refresh cycle, so samples queue up and the front end is held off.
  wire drain = !wdog_sync && !tick;
  wire pop = q_valid && drain;

  rtdwe_fifo #(
    .WIDTH(`RTDWE_Q_WIDTH),
    .DEPTH(`RTDWE_Q_DEPTH),
    .AW(`RTDWE_Q_AW)
  ) u_queue (
    .clk(CLOCK),
    .rst(RST),
    .in_valid(SAMPLE_VALID),
    .in_ready(SAMPLE_READY),
    .in_data({SAMPLE_CHANNEL, SAMPLE_OPEN, SAMPLE_TENTHS}),
    .out_valid(q_valid),
    .out_ready(drain),
    .out_data(q_data)
  );

  // ****************************************************************
  // Per-channel pending result and recovery timer
  // ****************************************************************
  reg [15:0] pend [0:1];
  reg [26:0] recover [0:1];
  reg [15:0] word [0:1];
  wire [15:0] code = rtdwe_encode(q_data[`RTDWE_Q_OPEN_BIT], q_data[15:0]);
  wire chan = q_data[`RTDWE_Q_CHAN_BIT];
  wire code_disc = (code == `RTDWE_CODE_DISCONNECT);
  integer i;

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (i = 0; i < 2; i = i + 1) begin
        pend[i] <= `RTDWE_CODE_NOT_READY;
        recover[i] <= 27'h0000000;
      end
    end else begin
      for (i = 0; i < 2; i = i + 1) begin
        if (pop && chan == i[0]) begin
          pend[i] <= code;
          if (pend[i] == `RTDWE_CODE_DISCONNECT && !code_disc) begin
            // Fresh data only after the front end has settled again
            recover[i] <= READY_CYCLES;
          end else if (code_disc) begin
            recover[i] <= 27'h0000000;
          end else if (recover[i] != 27'h0000000) begin
            recover[i] <= recover[i] - 27'h0000001;
          end
        end else if (recover[i] != 27'h0000000) begin
          recover[i] <= recover[i] - 27'h0000001;
        end
      end
    end
  end

  // ****************************************************************
  // Channel words, refreshed together once per conversion cycle and on every cycle of a fault
  // ****************************************************************
  reg [15:0] next_word [0:1];
  integer k;
  reg upd_lead;

  always @* begin
    for (k = 0; k < 2; k = k + 1) begin
      if (pu_busy || wdog_sync) begin
        next_word[k] = `RTDWE_CODE_NOT_READY;
      end else if (pend[k] == `RTDWE_CODE_DISCONNECT) begin
        next_word[k] = `RTDWE_CODE_DISCONNECT;
      end else if (recover[k] != 27'h0000000) begin
        next_word[k] = `RTDWE_CODE_NOT_READY;
      end else begin
        next_word[k] = pend[k];
      end
    end
  end

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      word[0] <= `RTDWE_CODE_NOT_READY;
      word[1] <= `RTDWE_CODE_NOT_READY;
      upd_lead <= 1'b0;
      WORD_UPDATE <= 1'b0;
    end else begin
      // A fault overrides at once; otherwise words move only on the tick
      if (tick || wdog_sync) begin
        word[0] <= next_word[0];
        word[1] <= next_word[1];
      end
      // Two stages, so the mark shares its cycle with the new output words
      upd_lead <= tick;
      WORD_UPDATE <= upd_lead;
    end
  end

  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      FIRST_CHANNEL_WORD <= `RTDWE_CODE_NOT_READY;
      SECOND_CHANNEL_WORD <= `RTDWE_CODE_NOT_READY;
    end else begin
      // Both words of the 32-point image, first channel in the low word
      FIRST_CHANNEL_WORD <= word[0];
      SECOND_CHANNEL_WORD <= word[1];
    end
  end

endmodule // rtdwe_top

// file: rtdwe_asserts.sv
// Output checker for the temperature word encoder.
// Assumes one CLOCK domain and an active-high asynchronous RST.
`timescale 1ns/1ps
`include "rtdwe_consts.vh"
module rtdwe_asserts #(
  parameter [26:0] CONV_CYCLES = 27'h0000014,
  parameter [26:0] READY_CYCLES = 27'h0000032
) (
  // Clock, reset, status
  input wire CLOCK,
  input wire RST,
  input wire WATCHDOG_FAULT,
  // Input image words
  input wire [15:0] FIRST_CHANNEL_WORD,
  input wire [15:0] SECOND_CHANNEL_WORD,
  input wire [7:0] FIRST_WORD_ADDR,
  input wire [7:0] SECOND_WORD_ADDR,
  input wire WORD_UPDATE
);
  reg [26:0] gap;
  reg [26:0] up;
  reg seen;
  // Counters rather than long repetitions keep the tools fast
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      gap <= 27'h0000000;
      up <= 27'h0000000;
      seen <= 1'b0;
    end else begin
      gap <= WORD_UPDATE ? 27'h0000001 : gap + 27'h0000001;
      up <= (up < READY_CYCLES) ? up + 27'h0000001 : up;
      seen <= seen | WORD_UPDATE;
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_update_pulse: assert property (WORD_UPDATE |=> !WORD_UPDATE)
    else $error("update pulse too long");
  a_tick_spacing: assert property (WORD_UPDATE && seen |-> gap == CONV_CYCLES)
    else $error("update spacing wrong");
  a_words_atomic: assert property (($changed(FIRST_CHANNEL_WORD)
    || $changed(SECOND_CHANNEL_WORD)) |-> WORD_UPDATE
    || FIRST_CHANNEL_WORD == `RTDWE_CODE_NOT_READY)
    else $error("word changed between updates");
  a_addr_pair: assert property (SECOND_WORD_ADDR == FIRST_WORD_ADDR + 8'h01)
    else $error("second word number not next");
  a_addr_base: assert property (FIRST_WORD_ADDR == `RTDWE_SLOT0_BASE
    || FIRST_WORD_ADDR == `RTDWE_SLOT1_BASE)
    else $error("word base wrong");
  a_first_range: assert property (($signed(FIRST_CHANNEL_WORD) >= -2150
    && $signed(FIRST_CHANNEL_WORD) <= 8650) || FIRST_CHANNEL_WORD[15:1] == 15'h2710)
    else $error("first word out of code set");
  a_second_range: assert property (($signed(SECOND_CHANNEL_WORD) >= -2150
    && $signed(SECOND_CHANNEL_WORD) <= 8650) || SECOND_CHANNEL_WORD[15:1] == 15'h2710)
    else $error("second word out of code set");
  a_powerup_busy: assert property (up < READY_CYCLES |->
    FIRST_CHANNEL_WORD == `RTDWE_CODE_NOT_READY && SECOND_CHANNEL_WORD == 16'h4E21)
    else $error("data before power-up ready");
  a_fault_busy: assert property (WATCHDOG_FAULT [*5] |->
    FIRST_CHANNEL_WORD == `RTDWE_CODE_NOT_READY && SECOND_CHANNEL_WORD == 16'h4E21)
    else $error("data during fault");
endmodule // rtdwe_asserts
bind rtdwe_top rtdwe_asserts #(.CONV_CYCLES(CONV_CYCLES), .READY_CYCLES(READY_CYCLES)) u_chk (
  .CLOCK(CLOCK), .RST(RST), .WATCHDOG_FAULT(WATCHDOG_FAULT),
  .FIRST_CHANNEL_WORD(FIRST_CHANNEL_WORD), .SECOND_CHANNEL_WORD(SECOND_CHANNEL_WORD),
  .FIRST_WORD_ADDR(FIRST_WORD_ADDR), .SECOND_WORD_ADDR(SECOND_WORD_ADDR),
  .WORD_UPDATE(WORD_UPDATE));

// file: rtdwe_front.sv
// Front-end model: offers one sample per request, holds it until taken.
// Assumes requests are raised just after a rising edge of clk.
`timescale 1ns/1ps
module rtdwe_front (
  // Clock and bench request
  input wire clk,
  input wire go,
  input wire [17:0] req,
  // Sample stream
  input wire ready,
  output reg valid,
  output reg [17:0] bus
);
  initial valid = 1'b0;
  initial bus = 18'h00000;
  // Released lines show the inverse so stale data never pass as fresh
  always @(posedge clk) begin
    if (valid && ready) begin
      valid <= 1'b0;
      bus <= ~bus;
    end else if (!valid && go) begin
      valid <= 1'b1;
      bus <= req;
    end
  end
endmodule // rtdwe_front

// file: tb_rtd_temperature_word_encoder.sv
// Self-checking bench of rtdwe_top with shortened counts.
// Assumes rtdwe_front as the sample source and the bound checker.
`timescale 1ns/1ps
`include "rtdwe_consts.vh"
module tb_rtd_temperature_word_encoder;
  // ****
  // Table rows {raw, expected}
  // ****
  localparam [351:0] ROWS = {32'h0000_0000, 32'hF830_F830, 32'h2134_2134, 32'hF82F_F82F,
    32'h2135_2135, 32'hF79A_F79A, 32'h21CA_21CA, 32'hF799_F79A, 32'h21CB_21CA,
    32'hF704_F79A, 32'h2328_21CA};
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg fault = 1'b0;
  reg slot = 1'b0;
  reg go = 1'b0;
  reg [17:0] req = 18'h00000;
  reg [31:0] r0;
  reg [31:0] r1;
  wire valid, ready, upd;
  wire [17:0] bus;
  wire [15:0] w0, w1;
  wire [7:0] a0, a1;
  integer num_errors = 0;
  integer checked = 0;
  integer i;
  integer n;
  always #12.5 clk = ~clk;
  rtdwe_top #(.CONV_CYCLES(27'h0000014), .READY_CYCLES(27'h0000032)) uut (.CLOCK(clk),
    .RST(rst), .SAMPLE_VALID(valid), .SAMPLE_READY(ready), .SAMPLE_CHANNEL(bus[17]),
    .SAMPLE_OPEN(bus[16]), .SAMPLE_TENTHS(bus[15:0]), .WATCHDOG_FAULT(fault),
    .SLOT_SELECT(slot), .FIRST_CHANNEL_WORD(w0), .SECOND_CHANNEL_WORD(w1),
    .FIRST_WORD_ADDR(a0), .SECOND_WORD_ADDR(a1), .WORD_UPDATE(upd));
  rtdwe_front fe (.clk(clk), .go(go), .req(req), .ready(ready), .valid(valid), .bus(bus));
  task chk(input [15:0] seen, input [15:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task send(input ch, input op, input [15:0] t);
    begin
      req = {ch, op, t};
      go = 1'b1;
      @(posedge clk) #1 go = 1'b0;
      n = 0;
      while (valid && n < 200) begin
        @(posedge clk) #1 n = n + 1;
      end
      if (valid) num_errors = num_errors + 1;
    end
  endtask
  task tick;
    begin
      n = 0;
      @(posedge clk) #1;
      while (upd !== 1'b1 && n < 100) begin
        @(posedge clk) #1 n = n + 1;
      end
      if (upd !== 1'b1) num_errors = num_errors + 1;
    end
  endtask
  task complete_run;
    begin
      if (num_errors == 0 && checked > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #1000000;
    num_errors = num_errors + 1;
    complete_run;
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 chk({w0[7:0], a0}, 16'h210A);
    chk({w1[7:0], a1}, 16'h210B);
    chk({upd, ready}, 16'h0001);
    rst = 1'b0;
    tick;
    chk(w0, `RTDWE_CODE_NOT_READY);
    tick;
    tick;
    chk(w1, `RTDWE_CODE_NOT_READY);
    for (i = 0; i < 11; i = i + 1) begin
      r0 = ROWS[32*i +: 32];
      r1 = ROWS[32*(10-i) +: 32];
      send(1'b0, 1'b0, r0[31:16]);
      send(1'b1, 1'b0, r1[31:16]);
      tick;
      tick;
      chk(w0, r0[15:0]);
      chk(w1, r1[15:0]);
    end
    send(1'b0, 1'b1, 16'h0000);
    send(1'b1, 1'b0, 16'hF703);
    tick;
    tick;
    chk(w0, `RTDWE_CODE_DISCONNECT);
    chk(w1, `RTDWE_CODE_DISCONNECT);
    send(1'b1, 1'b0, 16'h2329);
    send(1'b0, 1'b0, 16'h0064);
    tick;
    tick;
    chk(w0, `RTDWE_CODE_NOT_READY);
    chk(w1, `RTDWE_CODE_DISCONNECT);
    repeat (3) tick;
    chk(w0, 16'h0064);
    // Fault stops draining, so the queue fills while the far side stalls
    fault = 1'b1;
    tick;
    tick;
    chk(w0, `RTDWE_CODE_NOT_READY);
    i = 0;
    while (ready === 1'b1 && i < 40) begin
      send(1'b0, 1'b0, i[15:0]);
      i = i + 1;
    end
    chk(i[15:0], 16'h0021);
    fault = 1'b0;
    repeat (3) tick;
    chk({15'h0000, ready}, 16'h0001);
    chk(w0, 16'h0020);
    rst = 1'b1;
    slot = 1'b1;
    @(posedge clk) #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({a0, a1}, 16'h1415);
    complete_run;
  end
endmodule // tb_rtd_temperature_word_encoder
